/* inc/sftc_consts.vh */
// Purpose: constants for the source frame timing generator
// Assumes: one pixel per ref_clk cycle, counts in pixels and lines
// Notes: widths fixed, limits are the accepted raster bounds
`ifndef SFTC_CONSTS_VH
`define SFTC_CONSTS_VH

// field widths
`define SFTC_CW 12
`define SFTC_SW 14
`define SFTC_DW 30
`define SFTC_FIFO_DEPTH 8
`define SFTC_FIFO_AW 3

// vertical limits, in lines
`define SFTC_VSW_MIN 12'h001
`define SFTC_VBP_MIN 12'h002
`define SFTC_VFP_MIN 12'h001
`define SFTC_TVB_MIN 14'h001e

// horizontal limits, in pixel clocks
`define SFTC_HSW_MIN 12'h001
`define SFTC_HBP_MIN 12'h000
`define SFTC_HFP_MIN 12'h001
`define SFTC_THB_MIN 14'h0050

// active area limits
`define SFTC_LINE_PIX_MIN 12'h500
`define SFTC_LINE_PIX_MAX 12'hf00
`define SFTC_FRAME_LINES_MIN 12'h2d0
`define SFTC_FRAME_LINES_MAX 12'h870

// lane and byte mode codes
`define SFTC_LANES_1 2'h0
`define SFTC_LANES_2 2'h1
`define SFTC_LANES_4 2'h2
`define SFTC_LANES_8 2'h3
`define SFTC_BYTES_3 2'h0
`define SFTC_BYTES_4 2'h1
`define SFTC_BYTES_5 2'h2

// error flag positions
`define SFTC_E_VSW 0
`define SFTC_E_VBP 1
`define SFTC_E_VFP 2
`define SFTC_E_TVB 3
`define SFTC_E_HSW 4
`define SFTC_E_HBP 5
`define SFTC_E_HFP 6
`define SFTC_E_THB 7
`define SFTC_E_LINE_PIX 8
`define SFTC_E_FRAME_LINES 9
`define SFTC_E_LANE 10
`define SFTC_E_BYTE 11
`define SFTC_NERR 12

`endif

/* rtl/sftc_fifo.v */
// Purpose: small pixel fifo between the user stream and the raster
// Assumes: single clock, async active-low reset
// Notes: in_ready comes from a flop, out_valid from the count
`default_nettype none

module sftc_fifo #(
   parameter WIDTH = 30,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire ref_clk,
   input wire rst_n,
   input wire in_valid,
   input wire [WIDTH-1:0] in_data,
   output reg in_ready,
   output wire out_valid,
   output wire [WIDTH-1:0] out_data,
   input wire out_ready
);

   reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
   reg [AW-1:0] wr_q; // write pointer
   reg [AW-1:0] rd_q; // read pointer
   reg [AW:0] cnt_q; // words held
   reg [AW:0] cnt_d;
   wire push;
   wire pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];

   // next occupancy
   always @*
   begin
      cnt_d = cnt_q;
      if (push & ~pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop & ~push)
         cnt_d = cnt_q - 1'b1;
   end

   // storage write, no reset needed
   always @(posedge ref_clk)
   begin
      if (push)
         mem[wr_q] <= in_data;
   end

   // pointers, count and registered ready
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_d;
         in_ready <= (cnt_d != DEPTH[AW:0]); // honest full
      end
   end

endmodule // sftc_fifo
`default_nettype wire

/* rtl/sftc_source.v */
// Purpose: video source raster generator feeding the display input
// Assumes: one pixel per ref_clk, config inputs from same-clock logic
// Notes: config is checked and latched only at frame boundaries
// Notes: an illegal setup is refused and flagged, never clamped
// Notes: pixel words drain from a small fifo; a starved slot sends zero
`default_nettype none
`include "sftc_consts.vh"

// Overview of operation
// RL1 - vsync width at least one line
// RL2 - vertical back porch at least two lines
// RL3 - vertical front porch at least one line
// RL4 - total vertical blanking at least thirty lines
// RL5 - vertical blanking is back, front plus sync
// RL6 - vertical blanking split freely, porch minimums kept
// RL7 - hsync width at least one pixel clock
// RL8 - horizontal back porch may be zero
// RL9 - horizontal front porch at least one clock
// RL10 - total horizontal blanking at least eighty clocks
// RL11 - horizontal blanking is back, front plus sync
// RL12 - horizontal blanking split freely, minimums kept
// RL13 - active pixels per line 1280 to 3840
// RL14 - active lines per frame 720 to 2160
// RL15 - line width a multiple of lanes
// RL16 - one, two, four, eight lanes; 3/4/5 bytes
// RL17 - sticky flag names out-of-range timing parameter
module sftc_source (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // control
   input wire run,
   input wire err_clr,
   // frame geometry setup, pixels and lines
   input wire [`SFTC_CW-1:0] cfg_active_pixels_per_line,
   input wire [`SFTC_CW-1:0] cfg_active_lines_per_frame,
   input wire [`SFTC_CW-1:0] cfg_hsw,
   input wire [`SFTC_CW-1:0] cfg_hbp,
   input wire [`SFTC_CW-1:0] cfg_hfp,
   input wire [`SFTC_CW-1:0] cfg_vsw,
   input wire [`SFTC_CW-1:0] cfg_vbp,
   input wire [`SFTC_CW-1:0] cfg_vfp,
   // link mode setup
   input wire [1:0] cfg_lanes,
   input wire [1:0] cfg_bytes,
   // pixel stream in
   input wire pix_valid,
   input wire [`SFTC_DW-1:0] pix_data,
   output wire pix_ready,
   // raster out
   output reg vid_hsync_q,
   output reg vid_vsync_q,
   output reg vid_de_q,
   output reg [`SFTC_DW-1:0] vid_data_q,
   output reg [1:0] vid_lanes_q,
   output reg [1:0] vid_bytes_q,
   // status
   output reg busy_q,
   output reg underrun_q,
   output reg [`SFTC_NERR-1:0] cfg_err_q
);

   localparam ST_IDLE = 1'b0; // waiting for run and legal setup
   localparam ST_RUN = 1'b1; // raster running

   // raster geometry is held in end positions so the decode below
   // is plain compares against the running counters
   reg state_q; // generator state
   reg [`SFTC_SW-1:0] h_q; // pixel position in line
   reg [`SFTC_SW-1:0] v_q; // line position in frame
   reg [`SFTC_SW-1:0] hs_end_q; // first clock after hsync
   reg [`SFTC_SW-1:0] ha_beg_q; // first active pixel
   reg [`SFTC_SW-1:0] ha_end_q; // first front porch pixel
   reg [`SFTC_SW-1:0] h_last_q; // last clock of line
   reg [`SFTC_SW-1:0] vs_end_q; // first line after vsync
   reg [`SFTC_SW-1:0] va_beg_q; // first active line
   reg [`SFTC_SW-1:0] va_end_q; // first front porch line
   reg [`SFTC_SW-1:0] v_last_q; // last line of frame

   // sums run two bits wider than the setup fields so that three
   // maximal parts never wrap
   wire [`SFTC_SW-1:0] thb; // total horizontal blanking
   wire [`SFTC_SW-1:0] tvb; // total vertical blanking
   wire [`SFTC_SW-1:0] ha_beg_d;
   wire [`SFTC_SW-1:0] va_beg_d;
   wire [`SFTC_SW-1:0] ha_end_d;
   wire [`SFTC_SW-1:0] va_end_d;
   reg [`SFTC_CW-1:0] lane_mask; // low bits that must be zero
   reg [`SFTC_NERR-1:0] err_now; // violations of present setup
   wire legal; // setup may be used
   wire line_end;
   wire frame_end;
   wire h_act;
   wire v_act;
   wire de_now; // active pixel this cycle
   wire fifo_valid;
   wire [`SFTC_DW-1:0] fifo_data;
   wire pop;
   wire load; // latch setup this cycle

   // blanking totals from the three parts
   // the totals are judged on their own as well as each part, so a
   // setup with every part at its minimum is still refused
   // sync comes first, then back porch, active area, front porch
   assign thb = {2'b00, cfg_hsw} + {2'b00, cfg_hbp} + {2'b00, cfg_hfp}; // RL11
   assign tvb = {2'b00, cfg_vsw} + {2'b00, cfg_vbp} + {2'b00, cfg_vfp}; // RL5
   assign ha_beg_d = {2'b00, cfg_hsw} + {2'b00, cfg_hbp};
   assign va_beg_d = {2'b00, cfg_vsw} + {2'b00, cfg_vbp};
   assign ha_end_d = ha_beg_d + {2'b00, cfg_active_pixels_per_line};
   assign va_end_d = va_beg_d + {2'b00, cfg_active_lines_per_frame};

   // lane count to divisibility mask
   // lane counts are powers of two, so a multiple test is a mask
   // of the low bits instead of a divider
   always @*
   begin
      case (cfg_lanes)
         `SFTC_LANES_1: lane_mask = 12'h000;
         `SFTC_LANES_2: lane_mask = 12'h001;
         `SFTC_LANES_4: lane_mask = 12'h003;
         `SFTC_LANES_8: lane_mask = 12'h007;
         default: lane_mask = 12'h000;
      endcase
   end

   // per-parameter range check of the setup
   // every violation gets its own bit so software can see all of
   // them at once; the horizontal back porch minimum is zero and never trips
   // an unused byte code is treated as an illegal setup
   always @*
   begin
      err_now = {`SFTC_NERR{1'b0}};
      err_now[`SFTC_E_VSW] = (cfg_vsw < `SFTC_VSW_MIN); // RL1
      err_now[`SFTC_E_VBP] = (cfg_vbp < `SFTC_VBP_MIN); // RL2
      err_now[`SFTC_E_VFP] = (cfg_vfp < `SFTC_VFP_MIN); // RL3
      err_now[`SFTC_E_TVB] = (tvb < `SFTC_TVB_MIN); // RL4
      err_now[`SFTC_E_HSW] = (cfg_hsw < `SFTC_HSW_MIN); // RL7
      err_now[`SFTC_E_HBP] = (cfg_hbp < `SFTC_HBP_MIN); // RL8
      err_now[`SFTC_E_HFP] = (cfg_hfp < `SFTC_HFP_MIN); // RL9
      err_now[`SFTC_E_THB] = (thb < `SFTC_THB_MIN); // RL10
      err_now[`SFTC_E_LINE_PIX] = (cfg_active_pixels_per_line < `SFTC_LINE_PIX_MIN)
                                  | (cfg_active_pixels_per_line > `SFTC_LINE_PIX_MAX); // RL13
      err_now[`SFTC_E_FRAME_LINES] = (cfg_active_lines_per_frame < `SFTC_FRAME_LINES_MIN)
                                     | (cfg_active_lines_per_frame > `SFTC_FRAME_LINES_MAX); // RL14
      err_now[`SFTC_E_LANE] = ((cfg_active_pixels_per_line & lane_mask) != 12'h000); // RL15
      err_now[`SFTC_E_BYTE] = (cfg_bytes != `SFTC_BYTES_3) & (cfg_bytes != `SFTC_BYTES_4)
                              & (cfg_bytes != `SFTC_BYTES_5); // RL16
   end

   // each part checked on its own, split of blanking is free
   assign legal = (err_now == {`SFTC_NERR{1'b0}}); // RL6 RL12

   // raster position decode
   // compares use the latched geometry, so a setup change in mid
   // frame cannot tear the running raster
   assign line_end = (h_q == h_last_q);
   assign frame_end = line_end & (v_q == v_last_q);
   assign h_act = (h_q >= ha_beg_q) & (h_q < ha_end_q);
   assign v_act = (v_q >= va_beg_q) & (v_q < va_end_q);
   assign de_now = (state_q == ST_RUN) & h_act & v_act;
   assign pop = de_now & fifo_valid;

   // setup is taken at start and at every frame end
   // after reset, until a setup is latched, the idle decode also sees a frame end, which is harmless
   // because the idle branch ignores it
   assign load = run & legal & ((state_q == ST_IDLE) | frame_end);

   // pixel buffer in the data path
   // the user may fill it before run so the first line starts fed
   sftc_fifo #(
      .WIDTH(`SFTC_DW),
      .DEPTH(`SFTC_FIFO_DEPTH),
      .AW(`SFTC_FIFO_AW)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(pix_valid),
      .in_data(pix_data),
      .in_ready(pix_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(pop)
   );

   // state and raster counters
   // the generator only ever stops on a frame edge, so a sink never
   // sees a cut frame; dropping run mid frame finishes the frame
   // first, and an illegal new setup parks the generator idle
   // until a legal one is presented
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         h_q <= {`SFTC_SW{1'b0}};
         v_q <= {`SFTC_SW{1'b0}};
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               h_q <= {`SFTC_SW{1'b0}};
               v_q <= {`SFTC_SW{1'b0}};
               if (load)
                  state_q <= ST_RUN;
            end
            ST_RUN:
            begin
               if (frame_end)
               begin
                  h_q <= {`SFTC_SW{1'b0}};
                  v_q <= {`SFTC_SW{1'b0}};
                  if (!load)
                     state_q <= ST_IDLE; // stop only on a frame edge
               end
               else if (line_end)
               begin
                  h_q <= {`SFTC_SW{1'b0}};
                  v_q <= v_q + 1'b1;
               end
               else
                  h_q <= h_q + 1'b1;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // latched frame geometry, changed only between frames
   // last positions are stored minus one so the wrap compare is a
   // plain equality on the counter
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs_end_q <= {`SFTC_SW{1'b0}};
         ha_beg_q <= {`SFTC_SW{1'b0}};
         ha_end_q <= {`SFTC_SW{1'b0}};
         h_last_q <= {`SFTC_SW{1'b0}};
         vs_end_q <= {`SFTC_SW{1'b0}};
         va_beg_q <= {`SFTC_SW{1'b0}};
         va_end_q <= {`SFTC_SW{1'b0}};
         v_last_q <= {`SFTC_SW{1'b0}};
         vid_lanes_q <= `SFTC_LANES_1;
         vid_bytes_q <= `SFTC_BYTES_3;
      end
      else if (load)
      begin
         hs_end_q <= {2'b00, cfg_hsw};
         ha_beg_q <= ha_beg_d;
         ha_end_q <= ha_end_d;
         h_last_q <= ha_end_d + {2'b00, cfg_hfp} - 1'b1;
         vs_end_q <= {2'b00, cfg_vsw};
         va_beg_q <= va_beg_d;
         va_end_q <= va_end_d;
         v_last_q <= va_end_d + {2'b00, cfg_vfp} - 1'b1;
         vid_lanes_q <= cfg_lanes; // RL16
         vid_bytes_q <= cfg_bytes;
      end
   end

   // registered video outputs, one cycle behind position
   // every output leaves a flop so the far side sees clean edges;
   // syncs are active high and start at position zero
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vid_hsync_q <= 1'b0;
         vid_vsync_q <= 1'b0;
         vid_de_q <= 1'b0;
         vid_data_q <= {`SFTC_DW{1'b0}};
         busy_q <= 1'b0;
      end
      else
      begin
         vid_hsync_q <= (state_q == ST_RUN) & (h_q < hs_end_q); // RL7
         vid_vsync_q <= (state_q == ST_RUN) & (v_q < vs_end_q); // RL1
         vid_de_q <= de_now;
         vid_data_q <= pop ? fifo_data : {`SFTC_DW{1'b0}}; // blank when starved
         busy_q <= (state_q == ST_RUN);
      end
   end

   // sticky flags; a new event beats a clear in the same cycle
   // config flags are only refreshed where the setup is judged, so
   // a clear between judgements leaves them empty until the next
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_err_q <= {`SFTC_NERR{1'b0}};
         underrun_q <= 1'b0;
      end
      else
      begin
         if (run & ((state_q == ST_IDLE) | frame_end))
            cfg_err_q <= (err_clr ? {`SFTC_NERR{1'b0}} : cfg_err_q) | err_now; // RL17
         else if (err_clr)
            cfg_err_q <= {`SFTC_NERR{1'b0}};
         underrun_q <= (err_clr ? 1'b0 : underrun_q) | (de_now & ~fifo_valid);
      end
   end

endmodule // sftc_source
`default_nettype wire

/* dv/sftc_source_monitor.sv */
// Purpose: port timing checks on the source frame generator
// Assumes: one clock, setup judged whenever run is high while idle
// Notes: bound into every sftc_source instance
`default_nettype none
`include "sftc_consts.vh"
module sftc_source_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic err_clr,
   input wire logic [`SFTC_CW-1:0] cfg_active_pixels_per_line,
   input wire logic [`SFTC_CW-1:0] cfg_hsw,
   input wire logic [`SFTC_CW-1:0] cfg_hbp,
   input wire logic [`SFTC_CW-1:0] cfg_hfp,
   input wire logic [`SFTC_CW-1:0] cfg_vsw,
   input wire logic [`SFTC_CW-1:0] cfg_vbp,
   input wire logic [`SFTC_CW-1:0] cfg_vfp,
   input wire logic [1:0] cfg_lanes,
   input wire logic vid_hsync_q,
   input wire logic vid_vsync_q,
   input wire logic vid_de_q,
   input wire logic busy_q,
   input wire logic [`SFTC_NERR-1:0] cfg_err_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   wire eval = run && !busy_q; // setup judged while idle
   wire [13:0] vtot = cfg_vsw + cfg_vbp + cfg_vfp; // blanking lines
   wire [13:0] htot = cfg_hsw + cfg_hbp + cfg_hfp; // blanking clocks
   wire lane_bad = |(cfg_active_pixels_per_line & ((12'h001 << cfg_lanes) - 12'h001)); // width not lane multiple
   // front porch plus next sync keep de low two clocks
   sequence s_front;
      !vid_de_q [*2];
   endsequence
   a_vsw_flag: assert property (eval && cfg_vsw < `SFTC_VSW_MIN |=> cfg_err_q[`SFTC_E_VSW])
      else $error("short vsync not flagged");
   a_vbp_flag: assert property (eval && cfg_vbp < `SFTC_VBP_MIN |=> cfg_err_q[`SFTC_E_VBP])
      else $error("short back porch not flagged");
   a_vtot_flag: assert property (eval && vtot < `SFTC_TVB_MIN |=> cfg_err_q[`SFTC_E_TVB])
      else $error("short vertical blanking not flagged");
   a_htot_flag: assert property (eval && htot < `SFTC_THB_MIN |=> cfg_err_q[`SFTC_E_THB])
      else $error("short horizontal blanking not flagged");
   a_width_flag: assert property (eval && cfg_active_pixels_per_line > `SFTC_LINE_PIX_MAX
      |=> cfg_err_q[`SFTC_E_LINE_PIX])
      else $error("wide line not flagged");
   a_lane_flag: assert property (eval && lane_bad |=> cfg_err_q[`SFTC_E_LANE])
      else $error("lane remainder not flagged");
   a_flag_sticky: assert property (!err_clr |=> (cfg_err_q & $past(cfg_err_q)) == $past(cfg_err_q))
      else $error("flag dropped without clear");
   a_start_syncs: assert property ($rose(busy_q) |-> vid_hsync_q && vid_vsync_q && $past(run, 2))
      else $error("frame start wrong");
   a_front_gap: assert property ($fell(vid_de_q) |-> s_front)
      else $error("front porch too short");
endmodule // sftc_source_chk
bind sftc_source sftc_source_chk u_chk (.ref_clk, .rst_n, .run, .err_clr, .cfg_active_pixels_per_line, .cfg_hsw,
   .cfg_hbp, .cfg_hfp, .cfg_vsw, .cfg_vbp, .cfg_vfp, .cfg_lanes, .vid_hsync_q, .vid_vsync_q, .vid_de_q, .busy_q,
   .cfg_err_q);
`default_nettype wire

/* dv/sftc_sink.sv */
// Purpose: display input model measuring the incoming raster
// Assumes: active high syncs, one pixel per clock
// Notes: counts are positions within the line, in clocks
`default_nettype none
`include "sftc_consts.vh"
module sftc_sink (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsync,
   input wire logic vsync,
   input wire logic de,
   input wire logic [`SFTC_DW-1:0] data,
   output logic [13:0] m_hsw,
   output logic [13:0] m_dstart,
   output logic [13:0] m_active_pixels_per_line,
   output logic [13:0] m_vsw,
   output logic [13:0] m_thb,
   output logic [`SFTC_DW-1:0] m_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hl, vl, dl, got; // last samples, first word seen
   logic [13:0] c, ln; // clock in line, line in sync
   // measure each line and the sync width
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {hl, vl, dl, got, c, ln, m_hsw, m_dstart, m_active_pixels_per_line, m_vsw, m_thb, m_word} <= '0;
      end
      else
      begin
         {hl, vl, dl} <= {hsync, vsync, de};
         c <= (hsync && !hl) ? 14'h0001 : c + 14'h0001;
         if (hsync && !hl) m_thb <= c - m_active_pixels_per_line;
         if (hsync && !hl) ln <= (vsync && !vl) ? 14'h0001 : ln + 14'h0001;
         if (!vsync && vl) m_vsw <= ln;
         if (!hsync && hl) m_hsw <= c;
         if (de && !dl) m_dstart <= c;
         if (!de && dl) m_active_pixels_per_line <= c - m_dstart;
         if (de && !got) {got, m_word} <= {1'b1, data};
      end
   end
endmodule // sftc_sink
`default_nettype wire

/* dv/sftc_source_bench.sv */
// Purpose: self-checking bench for the source frame generator
// Assumes: sink model measures the raster lines
// Notes: frames are long, so only frame starts are walked
`default_nettype none
`include "sftc_consts.vh"
module sftc_source_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b0, err_clr = 1'b0, pix_valid = 1'b0;
   logic [`SFTC_CW-1:0] cfg_active_pixels_per_line, cfg_active_lines_per_frame;
   logic [`SFTC_CW-1:0] cfg_hsw, cfg_hbp, cfg_hfp, cfg_vsw, cfg_vbp, cfg_vfp;
   logic [1:0] cfg_lanes, cfg_bytes, vid_lanes_q, vid_bytes_q;
   logic [`SFTC_DW-1:0] pix_data = 30'h0, vid_data_q, m_word;
   logic pix_ready, vid_hsync_q, vid_vsync_q, vid_de_q, busy_q, underrun_q;
   logic [`SFTC_NERR-1:0] cfg_err_q;
   logic [13:0] m_hsw, m_dstart, m_active_pixels_per_line, m_vsw, m_thb;
   int error_cnt = 0, checked = 0, cyc = 0;
   sftc_source i_dut (.ref_clk, .rst_n, .run, .err_clr, .cfg_active_pixels_per_line, .cfg_active_lines_per_frame,
      .cfg_hsw, .cfg_hbp, .cfg_hfp, .cfg_vsw, .cfg_vbp, .cfg_vfp, .cfg_lanes, .cfg_bytes, .pix_valid, .pix_data,
      .pix_ready, .vid_hsync_q, .vid_vsync_q, .vid_de_q, .vid_data_q, .vid_lanes_q, .vid_bytes_q, .busy_q,
      .underrun_q, .cfg_err_q);
   sftc_sink i_sink (.ref_clk, .rst_n, .hsync(vid_hsync_q), .vsync(vid_vsync_q), .de(vid_de_q),
      .data(vid_data_q), .m_hsw, .m_dstart, .m_active_pixels_per_line, .m_vsw, .m_thb, .m_word);
   always #4 ref_clk = ~ref_clk;
   // cut a hang short; the longest scenario walks four lines of 1360
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 7000)
      begin
         error_cnt++;
         stop_test;
      end
   end
   task automatic stop_test;
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // typical legal setup, eight lanes
   task automatic cfg_default;
      {cfg_active_pixels_per_line, cfg_active_lines_per_frame} <= {12'h500, 12'h2d0};
      {cfg_lanes, cfg_bytes} <= {2'h3, 2'h0};
      {cfg_hsw, cfg_hbp, cfg_hfp} <= {12'h058, 12'h128, 12'h0b0};
      {cfg_vsw, cfg_vbp, cfg_vfp} <= {12'h00a, 12'h048, 12'h008};
   endtask
   task automatic do_reset;
      @(posedge ref_clk);
      {rst_n, run, pix_valid} <= 3'h0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask
   // one bad field per pass, flag bit equals pass index
   task automatic t_illegal;
      for (int k = 0; k < 12; k++)
      begin
         if (k == 5) continue;
         @(posedge ref_clk);
         cfg_default;
         case (k)
            0: cfg_vsw <= 12'h000;
            1: {cfg_vbp, cfg_vfp} <= {12'h001, 12'h050}; // total blanking stays legal
            2: cfg_vfp <= 12'h000;
            3: {cfg_vbp, cfg_vfp} <= {12'h012, 12'h001};
            4: cfg_hsw <= 12'h000;
            6: cfg_hfp <= 12'h000;
            7: {cfg_hsw, cfg_hbp, cfg_hfp} <= {12'h028, 12'h026, 12'h001};
            8: cfg_active_pixels_per_line <= 12'hf08;
            9: cfg_active_lines_per_frame <= 12'h2cf;
            10: cfg_active_pixels_per_line <= 12'h502;
            default: cfg_bytes <= 2'h3;
         endcase
         run <= 1'b1;
         repeat (3) @(posedge ref_clk);
         #1 chk(cfg_err_q, 32'h1 << k);
         chk(busy_q, 0);
         @(posedge ref_clk);
         {run, err_clr} <= 2'h1;
         @(posedge ref_clk);
         err_clr <= 1'b0;
         #1 chk(cfg_err_q, 0);
      end
   endtask
   // every lane count, byte modes in turn
   task automatic t_modes;
      for (int i = 0; i < 4; i++)
      begin
         do_reset;
         cfg_default;
         {cfg_lanes, cfg_bytes, run} <= {i[1:0], 2'(i % 3), 1'b1};
         @(posedge ref_clk);
         #1 chk(busy_q, 0);
         @(posedge ref_clk);
         #1 chk({busy_q, vid_hsync_q, vid_vsync_q}, 3'h7);
         chk({vid_lanes_q, vid_bytes_q}, {i[1:0], 2'(i % 3)});
      end
   endtask
   // minimum blanking, eight words queued then starved
   task automatic t_line;
      int taken;
      logic hit;
      taken = 0;
      do_reset;
      cfg_default;
      {cfg_hsw, cfg_hbp, cfg_hfp} <= {12'h001, 12'h000, 12'h04f};
      {cfg_vsw, cfg_vbp, cfg_vfp} <= {12'h001, 12'h002, 12'h01b};
      {pix_valid, pix_data} <= {1'b1, 30'h1};
      while (taken < 8)
      begin
         @(negedge ref_clk);
         hit = pix_ready;
         @(posedge ref_clk);
         if (hit)
         begin
            taken++;
            pix_data <= pix_data + 30'h1;
         end
      end
      pix_valid <= 1'b0;
      @(posedge ref_clk);
      #1 chk(pix_ready, 0);
      @(posedge ref_clk);
      run <= 1'b1;
      // active lines start at line three; line four opens the blanking count
      repeat (4 * 1360 + 8) @(posedge ref_clk);
      #1 chk(m_hsw, 1);
      chk(m_dstart, 1);
      chk(m_active_pixels_per_line, 1280);
      chk(m_thb, 80);
      chk(m_vsw, 1);
      chk(m_word, 1);
      chk({busy_q, underrun_q, cfg_err_q}, 14'h3000);
   endtask
   initial
   begin
      cfg_default;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1 chk({vid_hsync_q, vid_vsync_q, vid_de_q, busy_q, pix_ready, cfg_err_q}, 0);
      @(posedge ref_clk);
      #1 chk(pix_ready, 1);
      t_illegal;
      t_modes;
      t_line;
      stop_test;
   end
endmodule // sftc_source_bench
`default_nettype wire
